// ### watchdog_timer_unit_bench.sv
// Purpose: Self-checking bench of the watchdog timer unit.
// Assumes: Short base period so time-outs take a few thousand clocks.
// Notes:   Period bounds allow for the fractional tick spacing.
`timescale 1ns/10ps
module watchdog_timer_unit_bench
  import wdtu_pkg::*;
();
  localparam logic [20:0] PBASE = 21'h000004;
  logic       i_sys_clk, i_rst_n, fuse, gie, ack_en, wdr, dev_reset;
  logic       irq, srst, srst_d;
  logic [7:0] rdata;
  wdtu_bus_t  bus;
  wdtu_cpu_t  cpu;
  int         num_errors, checks_done, cyc, n_rst, t, n;

  wdtu_top #(.PERIOD_BASE(PBASE)) wdtu_top_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_dev_reset(dev_reset),
    .i_always_on_fuse(fuse), .i_bus(bus), .i_cpu(cpu), .o_rdata(rdata),
    .o_irq_req(irq), .o_sys_reset(srst));
  wdtu_cpu_model wdtu_cpu_model_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_irq_req(irq),
    .i_sys_reset(srst), .i_gie(gie), .i_ack_en(ack_en), .i_wdr(wdr),
    .o_cpu(cpu), .o_dev_reset(dev_reset));

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  // ==========================================================================
  // Checks and bus
  task automatic close_out();
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check8(string name, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(string name, logic exp, logic got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd_chk(string name, logic [7:0] a, logic [7:0] exp);
    @(posedge i_sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1 check8(name, exp, rdata);
  endtask
  // Counts edges until the output shows, giving up at lim
  task automatic wait_evt(logic is_rst, int lim);
    t = 0;
    while ((is_rst ? srst : irq) !== 1'b1 && t < lim) begin
      @(posedge i_sys_clk);
      #1 t++;
    end
  endtask
  task automatic disarm();
    wr(ADDR_CAUSE, 8'h00);
    wr(ADDR_PROT, PROT_SIG);
    wr(ADDR_CTRL, 8'h80);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic s_reset_values();
    rd_chk("ctrl_rst", ADDR_CTRL, CTRL_RST);
    rd_chk("cause_rst", ADDR_CAUSE, 8'h00);
    rd_chk("prot_rd", ADDR_PROT, 8'h00);
    rd_chk("unmapped", 8'h20, 8'h00);
    wr(8'h20, 8'hFF);
    repeat (1700) @(posedge i_sys_clk);
    check_bit("stop_no_rst", 1'b1, n_rst == 0);
    rd_chk("stop_no_flag", ADDR_CTRL, 8'h00);
  endtask
  task automatic s_protect();
    wr(ADDR_CTRL, 8'h08);
    rd_chk("sre_set", ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h01);
    rd_chk("sel_free", ADDR_CTRL, 8'h09);
    wr(ADDR_PROT, PROT_SIG);
    repeat (12) @(posedge i_sys_clk);
    wr(ADDR_CTRL, 8'h01);
    rd_chk("win_closed", ADDR_CTRL, 8'h09);
    disarm();
    rd_chk("disabled", ADDR_CTRL, 8'h00);
  endtask
  task automatic s_reset_mode();
    for (int s = 0; s < 2; s++) begin
      n = int'(PBASE) << s;
      wr(ADDR_CTRL, 8'h08 | 8'(s));
      wait_evt(1'b1, 4000);
      check_bit("period", 1'b1, t >= (n - 1) * 390 && t <= n * 391 + 4);
      rd_chk("dog_flag", ADDR_CAUSE, 8'h08);
      rd_chk("sre_forced", ADDR_CTRL, 8'h08);
      wr(ADDR_PROT, PROT_SIG);
      wr(ADDR_CTRL, 8'h00);
      rd_chk("sre_held", ADDR_CTRL, 8'h08);
      disarm();
      rd_chk("flag_w0", ADDR_CAUSE, 8'h00);
      rd_chk("sre_clr", ADDR_CTRL, 8'h00);
    end
  endtask
  task automatic s_restart();
    int base;
    base = n_rst;
    wr(ADDR_CTRL, 8'h08);
    repeat (10) begin
      repeat (300) @(posedge i_sys_clk);
      wdr <= 1'b1;
      @(posedge i_sys_clk);
      wdr <= 1'b0;
    end
    check_bit("wdr_holds", 1'b1, n_rst == base);
    disarm();
  endtask
  task automatic s_irq();
    int base;
    base = n_rst;
    wr(ADDR_CTRL, 8'h40);
    repeat (1700) @(posedge i_sys_clk);
    #1 check_bit("irq_masked", 1'b0, irq);
    rd_chk("flag_set", ADDR_CTRL, 8'hC0);
    @(posedge i_sys_clk);
    gie <= 1'b1;
    wait_evt(1'b0, 6);
    check_bit("irq_req", 1'b1, irq);
    check_bit("irq_no_rst", 1'b1, n_rst == base);
    wr(ADDR_CTRL, 8'hC0);
    rd_chk("flag_w1c", ADDR_CTRL, 8'h40);
    check_bit("irq_drop", 1'b0, irq);
    disarm();
  endtask
  task automatic s_both();
    ack_en <= 1'b1;
    wr(ADDR_CTRL, 8'h48);
    wait_evt(1'b0, 1700);
    check_bit("both_irq", 1'b1, irq);
    repeat (4) @(posedge i_sys_clk);
    rd_chk("vec_clears", ADDR_CTRL, 8'h08);
    wait_evt(1'b1, 1700);
    check_bit("then_reset", 1'b1, srst);
    disarm();
    ack_en <= 1'b0;
    wr(ADDR_CTRL, 8'h48);
    wait_evt(1'b1, 3300);
    check_bit("unserviced", 1'b1,
              srst && t >= (2 * int'(PBASE) - 1) * 390);
    disarm();
  endtask
  task automatic s_level2();
    fuse <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    rd_chk("l2_sre", ADDR_CTRL, 8'h08);
    wr(ADDR_CTRL, 8'h01);
    rd_chk("l2_locked", ADDR_CTRL, 8'h08);
    wr(ADDR_PROT, PROT_SIG);
    wr(ADDR_CTRL, 8'h01);
    rd_chk("l2_change", ADDR_CTRL, 8'h09);
    wait_evt(1'b1, 3300);
    check_bit("l2_resets", 1'b1, srst);
  endtask

  // ==========================================================================
  // Pulse watch and hang guard
  always @(posedge i_sys_clk) begin
    if (srst === 1'b1) begin
      n_rst++;
      check_bit("pulse_len", 1'b0, srst_d);
    end
    srst_d = srst;
    if (++cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    i_rst_n = 1'b0;
    fuse = 1'b0;
    gie = 1'b0;
    ack_en = 1'b0;
    wdr = 1'b0;
    bus = '0;
    srst_d = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    s_reset_values();
    s_protect();
    s_reset_mode();
    s_restart();
    s_irq();
    s_both();
    s_level2();
    close_out();
  end
endmodule

// ### wdtu_cpu_model.sv
// Purpose: CPU core model: instruction cycles, restart, vector, reset.
// Assumes: Shares the system clock with the watchdog.
// Notes:   Runs each vector once per request; never re-arms the enable.
`timescale 1ns/10ps
module wdtu_cpu_model
  import wdtu_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_irq_req,
  input  wire logic i_sys_reset,
  input  wire logic i_gie,
  input  wire logic i_ack_en,
  input  wire logic i_wdr,
  output wdtu_cpu_t o_cpu,
  output logic      o_dev_reset
);
  // ==========================================================================
  // Core
  logic seen_ff;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cpu       <= '0;
      seen_ff     <= 1'b0;
      o_dev_reset <= 1'b0;
    end else begin
      // Two clocks per instruction keeps the window longer than one bus op
      o_cpu.insn_cycle <= ~o_cpu.insn_cycle;
      o_cpu.gie        <= i_gie;
      o_cpu.wdr        <= i_wdr;
      // The handler leaves the enable alone; the bench re-arms it
      o_cpu.irq_ack    <= i_irq_req & i_ack_en & ~seen_ff;
      seen_ff          <= i_irq_req;
      o_dev_reset      <= i_sys_reset;
    end
  end
endmodule

// ### wdtu_pkg.sv
// Purpose: Shared constants and carrier types of the watchdog timer unit.
// Assumes: 8-bit register port, 50 MHz system clock, 128 kHz count rate.
// Notes:   Offsets are I/O addresses, not byte addresses of a wide bus.
package wdtu_pkg;

  // ==========================================================================
  // Register port
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 8;
  localparam logic [7:0]  ADDR_CTRL  = 8'h31;
  localparam logic [7:0]  ADDR_CAUSE = 8'h3B;
  localparam logic [7:0]  ADDR_PROT  = 8'h3C;
  localparam logic [7:0]  PROT_SIG   = 8'hD8;
  localparam logic [7:0]  CTRL_RST   = 8'h00;

  // ==========================================================================
  // Field positions of watchdog_control_status and reset_cause_register
  localparam int          BIT_FLAG   = 7;
  localparam int          BIT_IE     = 6;
  localparam int          BIT_SEL3   = 5;
  localparam int          BIT_SRE    = 3;
  localparam int          BIT_DOGRF  = 3;

  // ==========================================================================
  // Timing
  localparam int          SYS_CLK_KHZ     = 50000;
  localparam int          OSC_KHZ         = 128;
  localparam int          ACC_W           = 16;
  localparam logic [2:0]  WIN_INSNS       = 3'h4;
  localparam int          CNT_W           = 20;
  localparam logic [20:0] PERIOD_BASE_CYC = 21'h000800;
  localparam logic [3:0]  SEL_MAX         = 4'h9;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    WDTU_STOP,
    WDTU_IRQ,
    WDTU_RST,
    WDTU_BOTH
  } wdtu_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } wdtu_bus_t;

  typedef struct packed {
    logic wdr;
    logic insn_cycle;
    logic gie;
    logic irq_ack;
  } wdtu_cpu_t;

endpackage

// ### wdtu_tick_gen.sv
// Purpose: Derives the 128 kHz watchdog count enable from the system clock.
// Assumes: System clock rate and tick rate given in kHz.
// Notes:   The ratio is fractional, so a phase accumulator spreads the error.
`timescale 1ns/10ps
module wdtu_tick_gen
  import wdtu_pkg::*;
#(
  parameter int CLK_KHZ  = SYS_CLK_KHZ,
  parameter int TICK_KHZ = OSC_KHZ
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);

  localparam logic [ACC_W-1:0] STEP = ACC_W'(TICK_KHZ);
  localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_KHZ - TICK_KHZ);

  logic [ACC_W-1:0] acc_ff;

  // ==========================================================================
  // Phase accumulator
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_ff <= '0;
      o_tick <= 1'b0;
    end else if (acc_ff >= WRAP) begin
      acc_ff <= acc_ff - WRAP;
      o_tick <= 1'b1;
    end else begin
      acc_ff <= acc_ff + STEP;
      o_tick <= 1'b0;
    end
  end

endmodule

// ### wdtu_top.sv
// Purpose: Watchdog timer unit: counter, mode logic, protected changes.
// Assumes: CPU signals share the system clock; the fuse is a static strap.
// Notes:   i_rst_n is the power-on reset; i_dev_reset is any device reset.
`timescale 1ns/10ps
// How it works
// - Counter advances only on the derived 128 kHz oscillator tick.
// - Counter clears on restart instruction, when stopped, and on device reset.
// - Reset-mode time-out without restart fires a system reset.
// - Counting ignores sleep state; the tick never stops while enabled.
// - Level 1 starts disabled; reset-enable may be set and period changed freely.
// - Level 1 reset-enable clears only in a write inside the protection window or on device reset.
// - Level 2 is always enabled and reset-enable reads as one.
// - Level 2 period changes only inside the window; enable bit is ignored.
// - Enable bits pick stopped, interrupt, reset or both; fuse forces reset.
// - Flag bit 7 sets on interrupt time-out; vector or writing one clears.
// - Interrupt request needs global enable, interrupt enable and the flag.
// - In combined mode the vector clears interrupt enable and flag.
// - Combined mode: unserviced flag at next time-out causes system reset.
// - Reset-enable is forced high while the dog reset flag is set.
// - Period code selects 2048 doubling to 1048576 ticks; codes above 9 reserved.
// - A reset-causing time-out emits a one system clock reset pulse.
// - Dog reset flag sets on watchdog reset; only power-on or zero write clears.
module wdtu_top
  import wdtu_pkg::*;
#(
  parameter logic [20:0] PERIOD_BASE = PERIOD_BASE_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_dev_reset,
  input  wire logic        i_always_on_fuse,
  input  wdtu_bus_t        i_bus,
  input  wdtu_cpu_t        i_cpu,
  output logic [DATA_W-1:0] o_rdata,
  output logic             o_irq_req,
  output logic             o_sys_reset
);

  logic             fuse_s1_ff;
  logic             fuse_ff;
  logic             tick;
  logic [2:0]       win_cnt_ff;
  logic             win_open;
  logic             flag_ff;
  logic             ie_ff;
  logic             sre_ff;
  logic [3:0]       sel_ff;
  logic             dog_flag_ff;
  logic [CNT_W-1:0] count_ff;
  logic             sre_rd;
  wdtu_mode_t       mode;
  logic             ctrl_wr;
  logic             prot_wr;
  logic             cause_wr;
  logic             timeout;
  logic             reset_fire;
  logic             flag_set;
  logic [DATA_W-1:0] nxt_rdata;

  // ==========================================================================
  // Helpers
  // Reserved codes behave as the longest period rather than a short one
  function automatic logic [CNT_W-1:0] last_count(input logic [3:0] s);
    logic [3:0]  k;
    logic [20:0] v;
    k = (s > SEL_MAX) ? SEL_MAX : s;
    v = PERIOD_BASE << k;
    return CNT_W'(v - 21'h000001);
  endfunction

  // ==========================================================================
  // Fuse strap and tick
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fuse_s1_ff <= 1'b0;
      fuse_ff    <= 1'b0;
    end else begin
      fuse_s1_ff <= i_always_on_fuse;
      fuse_ff    <= fuse_s1_ff;
    end
  end

  // Free running, independent of sleep and of the CPU clock gating
  wdtu_tick_gen wdtu_tick_gen_i (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .o_tick    (tick)
  );

  // ==========================================================================
  // Decode and mode
  assign ctrl_wr  = i_bus.wr && (i_bus.addr == ADDR_CTRL);
  assign prot_wr  = i_bus.wr && (i_bus.addr == ADDR_PROT);
  assign cause_wr = i_bus.wr && (i_bus.addr == ADDR_CAUSE);
  assign win_open = (win_cnt_ff != 3'h0);

  assign sre_rd = sre_ff | fuse_ff | dog_flag_ff;

  always_comb begin
    mode = WDTU_STOP;
    if (fuse_ff) begin
      mode = WDTU_RST;
    end else begin
      case ({sre_rd, ie_ff})
        2'b01:   mode = WDTU_IRQ;
        2'b10:   mode = WDTU_RST;
        2'b11:   mode = WDTU_BOTH;
        default: mode = WDTU_STOP;
      endcase
    end
  end

  // A period shortened below the running count times out on the next tick
  // instead of waiting for the counter to wrap
  assign timeout    = tick && (mode != WDTU_STOP) &&
                      (count_ff >= last_count(sel_ff));
  assign reset_fire = timeout && ((mode == WDTU_RST) ||
                      ((mode == WDTU_BOTH) && flag_ff));
  assign flag_set   = timeout && ((mode == WDTU_IRQ) ||
                      ((mode == WDTU_BOTH) && !flag_ff));

  // ==========================================================================
  // Protection window
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      win_cnt_ff <= 3'h0;
    end else if (i_dev_reset) begin
      win_cnt_ff <= 3'h0;
    end else if (prot_wr && (i_bus.wdata == PROT_SIG)) begin
      win_cnt_ff <= WIN_INSNS;
    end else if (ctrl_wr) begin
      win_cnt_ff <= 3'h0;
    end else if (i_cpu.insn_cycle && win_open) begin
      win_cnt_ff <= win_cnt_ff - 3'h1;
    end
  end

  // ==========================================================================
  // Counter
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_ff <= '0;
    end else if (i_dev_reset || i_cpu.wdr || (mode == WDTU_STOP)) begin
      count_ff <= '0;
    end else if (timeout) begin
      count_ff <= '0;
    end else if (tick) begin
      count_ff <= count_ff + CNT_W'(1);
    end
  end

  // ==========================================================================
  // Control fields
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_ff <= 1'b0;
    end else if (i_dev_reset) begin
      flag_ff <= 1'b0;
    end else if (flag_set) begin
      flag_ff <= 1'b1;
    end else if (i_cpu.irq_ack || (ctrl_wr && i_bus.wdata[BIT_FLAG])) begin
      flag_ff <= 1'b0;
    end
  end

  // Hardware clear on the vector beats a software write in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ie_ff <= 1'b0;
    end else if (i_dev_reset) begin
      ie_ff <= 1'b0;
    end else if (i_cpu.irq_ack && (mode == WDTU_BOTH)) begin
      ie_ff <= 1'b0;
    end else if (ctrl_wr) begin
      ie_ff <= i_bus.wdata[BIT_IE];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_ff <= 4'h0;
    end else if (i_dev_reset) begin
      sel_ff <= 4'h0;
    end else if (ctrl_wr && (!fuse_ff || win_open)) begin
      sel_ff <= {i_bus.wdata[BIT_SEL3], i_bus.wdata[2:0]};
    end
  end

  // Stored copy latches high under the flag, so clearing the flag alone
  // never silently disables the watchdog
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sre_ff <= 1'b0;
    end else if (i_dev_reset) begin
      sre_ff <= 1'b0;
    end else if (dog_flag_ff || reset_fire) begin
      sre_ff <= 1'b1;
    end else if (ctrl_wr && !fuse_ff) begin
      if (i_bus.wdata[BIT_SRE]) begin
        sre_ff <= 1'b1;
      end else if (win_open) begin
        sre_ff <= 1'b0;
      end
    end
  end

  // Survives device resets; only power-on clears it besides software
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dog_flag_ff <= 1'b0;
    end else if (reset_fire) begin
      dog_flag_ff <= 1'b1;
    end else if (cause_wr && !i_bus.wdata[BIT_DOGRF]) begin
      dog_flag_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sys_reset <= 1'b0;
    end else begin
      o_sys_reset <= reset_fire;
    end
  end

  // Software keeps combined mode by re-arming the enable after the ISR
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req <= 1'b0;
    end else begin
      o_irq_req <= flag_ff && ie_ff && i_cpu.gie && !i_dev_reset;
    end
  end

  always_comb begin
    nxt_rdata = '0;
    if (i_bus.addr == ADDR_CTRL) begin
      nxt_rdata = {flag_ff, ie_ff, sel_ff[3], 1'b0, sre_rd, sel_ff[2:0]};
    end else if (i_bus.addr == ADDR_CAUSE) begin
      nxt_rdata = {4'h0, dog_flag_ff, 3'h0};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_bus.rd) begin
      o_rdata <= nxt_rdata;
    end else begin
      o_rdata <= '0;
    end
  end

  // ==========================================================================
  // Checks
  sequence s_sig_write;
    prot_wr && (i_bus.wdata == PROT_SIG) && !i_dev_reset;
  endsequence

  sequence s_ctrl_closed;
    ctrl_wr && !win_open && !i_dev_reset;
  endsequence

  sequence s_reset_timeout;
    timeout && (mode == WDTU_RST) && !i_dev_reset;
  endsequence

  AST_RST_ONE_CYCLE: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_sys_reset |=> !o_sys_reset)
    else $error("system reset pulse longer than one cycle");

  AST_RST_SETS_FLAG: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_sys_reset |-> dog_flag_ff && sre_rd)
    else $error("dog reset flag not set by watchdog reset");

  AST_SRE_FORCED: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (dog_flag_ff || fuse_ff) |-> nxt_rdata[BIT_SRE] ||
      (i_bus.addr != ADDR_CTRL))
    else $error("reset enable reads zero while forced");

  AST_LVL2_MODE: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    fuse_ff |-> (mode == WDTU_RST) && !flag_set)
    else $error("always-on level left system reset mode");

  AST_IRQ_GATE: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_irq_req |-> $past(flag_ff) && $past(ie_ff) && $past(i_cpu.gie))
    else $error("interrupt request without all enables");

  AST_WDR_CLEARS: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_cpu.wdr |=> (count_ff == '0))
    else $error("restart instruction did not clear counter");

  AST_WINDOW_OPEN: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_sig_write |=> (win_cnt_ff == WIN_INSNS))
    else $error("signature write did not open the window");

  AST_LVL2_PERIOD_HELD: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_ctrl_closed ##0 fuse_ff |=> $stable(sel_ff))
    else $error("period changed outside protection window");

  AST_LVL1_NO_DISABLE: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_ctrl_closed ##0 (!fuse_ff && sre_ff) |=> sre_ff)
    else $error("reset enable cleared outside protection window");

  AST_COMBINED_ACK: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_cpu.irq_ack && (mode == WDTU_BOTH) && !flag_set && !i_dev_reset)
      |=> !ie_ff && !flag_ff)
    else $error("vector did not clear enable and flag");

  AST_RST_MODE_FIRES: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    s_reset_timeout |=> o_sys_reset)
    else $error("reset mode time-out gave no system reset");

  AST_IRQ_MODE_NO_RST: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (timeout && (mode == WDTU_IRQ)) |=> !o_sys_reset)
    else $error("interrupt mode time-out caused a system reset");

  AST_FLAG_SET_WINS: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (flag_set && !i_dev_reset) |=> flag_ff)
    else $error("time-out did not set the interrupt flag");

  AST_FLAG_W1C: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (ctrl_wr && i_bus.wdata[BIT_FLAG] && !flag_set && !i_dev_reset)
      |=> !flag_ff)
    else $error("writing one did not clear the interrupt flag");

  AST_DOG_FLAG_KEPT: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (dog_flag_ff && !(cause_wr && !i_bus.wdata[BIT_DOGRF]))
      |=> dog_flag_ff)
    else $error("dog reset flag lost without a zero write");

  AST_STOP_CLEARS: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (mode == WDTU_STOP) |=> (count_ff == '0))
    else $error("stopped watchdog did not clear its counter");

  AST_DEVRST_MASKS_IRQ: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_dev_reset |=> !o_irq_req)
    else $error("interrupt request raised during device reset");

endmodule
